/* File: rtl/mcode_handler.sv */
// firmware-download command handler with an AHB-Lite register slave
// assumes one AHB-Lite master, word transfers, one clock
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "mcode_map.svh"

// Notes on behaviour
// - only opcode 92h is taken as the download command
// - block count is number-byte high, count-byte low
// - buffer offset is address bits 23:8, count high byte bits 7:0
// - offset is checked only for subcommands 03h and 0Eh
// - a zero block count finishes at once with no data
// - offset counts 512-byte blocks from image start
// - offset not equal previous end aborts and discards the image
// - final segment is verified, then the image is saved
// - subcommands 03h and 07h activate at once after the last segment
// - subcommand 0Eh stores the verified image as pending only
// - pending image activates only on subcommand 0Fh
// - reset before the final segment drops all received data
// - reset drops a stored image that was not activated
// - abort on an undefined subcommand or while security locked
// - uncorrectable when a 03h/07h image fails verification or a requested reload fails
// - with spin-up disabled, spin down after a reload
module mcode_handler (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             fw_activate,
	output logic             spin_down,
	output logic             cmd_done
);

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [31:0] a, input logic [7:0] ofs);
		reg_hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
	endfunction

	mcode_pkg::cmd_state_e state;

	logic        wr_pend;
	logic [31:0] wr_addr;
	logic [7:0]  count_reg;
	logic [27:0] lba_reg;
	logic [31:0] ctrl_reg;
	logic [7:0]  sub;
	logic [15:0] rem;
	logic [15:0] expect_ofs;
	logic [15:0] seg_stop;
	logic        seg_final;
	logic        pending;
	logic [7:0]  err_reg;
	logic        status_err;

	img_if img ();

	img_checker u_chk (
		.clk  (clk),
		.rstn (rstn),
		.img  (img.chk)
	);

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	wire        acc       = hsel & hready & htrans[1];
	wire        go        = wr_pend & reg_hit(wr_addr, `OFS_CMD) &
		(state == mcode_pkg::ST_IDLE);
	wire [7:0]  go_opc    = hwdata[7:0];
	wire [7:0]  go_sub    = hwdata[15:8];
	wire [15:0] blocks    = {lba_reg[`LBA_CNTHI_MSB:0], count_reg};
	wire [15:0] offs      = lba_reg[`LBA_OFS_MSB:`LBA_OFS_LSB];
	wire [16:0] seg_end   = {1'b0, offs} + {1'b0, blocks};
	wire        sub_07    = (go_sub == `SUB_SAVE);
	wire        sub_0f    = (go_sub == `SUB_ACTIVATE);
	wire        ofs_mode  = (go_sub == `SUB_OFS_SAVE) |
		(go_sub == `SUB_OFS_DEFER);
	wire        sub_ok    = ofs_mode | sub_07 | sub_0f;
	wire        locked    = ctrl_reg[`CTRL_LOCK_BIT];
	wire        bad_cmd   = (go_opc != `OPC_DOWNLOAD) | ~sub_ok | locked;
	wire        ofs_bad   = ofs_mode & (offs != expect_ofs);
	wire        act_bad   = sub_0f & ~pending;
	wire        verify_ok = (img.sum == 32'h0000_0000);
	wire        rfail     = ctrl_reg[`CTRL_RFAIL_BIT];
	wire        nospin    = ctrl_reg[`CTRL_NOSPIN_BIT];
	wire [16:0] img_size  = {1'b0, ctrl_reg[`CTRL_SIZE_MSB:`CTRL_SIZE_LSB]};
	wire        fin_now   = (state == mcode_pkg::ST_FINISH) & seg_final;
	wire        fin_defer = fin_now & (sub == `SUB_OFS_DEFER);
	// causes of a reload, sampled one cycle back by the checks
	wire        fin_imm   = fin_now & ~fin_defer;
	wire        act_req   = go & sub_0f;

	// ----------------------------------------------------------------
	// image checker feed
	// ----------------------------------------------------------------
	assign img.word_valid = wr_pend & reg_hit(wr_addr, `OFS_DATA) &
		(state == mcode_pkg::ST_XFER);
	assign img.word       = hwdata;
	assign img.restart    = go;
	// new image, or discard of a broken one
	assign img.clear      = go & ~bad_cmd &
		(sub_07 | (ofs_mode & (ofs_bad | (offs == 16'h0000))));

	// ----------------------------------------------------------------
	// bus slave: address phase capture and read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend <= 1'b0;
			wr_addr <= 32'h0000_0000;
		end else begin
			wr_pend <= acc & hwrite & (hsize == `HSIZE_WORD);
			wr_addr <= haddr;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (acc & ~hwrite) begin
			if (reg_hit(haddr, `OFS_CMD)) begin
				hrdata <= {expect_ofs, sub, `OPC_DOWNLOAD};
			end else if (reg_hit(haddr, `OFS_COUNT)) begin
				hrdata <= {24'h00_0000, count_reg};
			end else if (reg_hit(haddr, `OFS_LBA)) begin
				hrdata <= {4'h0, lba_reg};
			end else if (reg_hit(haddr, `OFS_CTRL)) begin
				hrdata <= ctrl_reg;
			end else if (reg_hit(haddr, `OFS_STAT)) begin
				hrdata <= {15'h0000, pending, err_reg,
					(state == mcode_pkg::ST_FINISH), 3'h0,
					(state == mcode_pkg::ST_XFER), 2'h0, status_err};
			end else begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// task file and control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 8'h00;
			lba_reg   <= 28'h000_0000;
			ctrl_reg  <= `CTRL_RESET;
		end else if (wr_pend) begin
			if (reg_hit(wr_addr, `OFS_COUNT)) begin
				count_reg <= hwdata[7:0];
			end
			if (reg_hit(wr_addr, `OFS_LBA)) begin
				lba_reg <= hwdata[27:0];
			end
			if (reg_hit(wr_addr, `OFS_CTRL)) begin
				ctrl_reg <= hwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// command sequencer
	// ----------------------------------------------------------------
	// async reset clears pending and expected offset: image is lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state       <= mcode_pkg::ST_IDLE;
			sub         <= 8'h00;
			rem         <= 16'h0000;
			seg_stop    <= 16'h0000;
			seg_final   <= 1'b0;
			expect_ofs  <= 16'h0000;
			pending     <= 1'b0;
			err_reg     <= 8'h00;
			status_err  <= 1'b0;
			cmd_done    <= 1'b0;
			fw_activate <= 1'b0;
			spin_down   <= 1'b0;
		end else begin
			cmd_done    <= 1'b0;
			fw_activate <= 1'b0;
			spin_down   <= 1'b0;
			case (state)
				mcode_pkg::ST_IDLE: begin
					if (go) begin
						sub        <= go_sub;
						rem        <= blocks;
						seg_stop   <= seg_end[15:0];
						seg_final  <= sub_07 | (seg_end >= img_size);
						err_reg    <= 8'h00;
						status_err <= 1'b0;
						if (bad_cmd | act_bad) begin
							err_reg[`ERR_ABORT_BIT] <= 1'b1;
							status_err              <= 1'b1;
							cmd_done                <= 1'b1;
						end else if (ofs_bad) begin
							err_reg[`ERR_ABORT_BIT] <= 1'b1;
							status_err              <= 1'b1;
							expect_ofs              <= 16'h0000;
							cmd_done                <= 1'b1;
						end else if (sub_0f) begin
							pending  <= 1'b0;
							cmd_done <= 1'b1;
							if (rfail) begin
								err_reg[`ERR_UNC_BIT] <= 1'b1;
								status_err            <= 1'b1;
							end else begin
								fw_activate <= 1'b1;
								spin_down   <= nospin;
							end
						end else if (blocks == 16'h0000) begin
							cmd_done <= 1'b1;
						end else begin
							state <= mcode_pkg::ST_XFER;
						end
					end
				end
				mcode_pkg::ST_XFER: begin
					if (img.block_done) begin
						rem <= rem - 16'h0001;
						if (rem == 16'h0001) begin
							state <= mcode_pkg::ST_FINISH;
						end
					end
				end
				mcode_pkg::ST_FINISH: begin
					state    <= mcode_pkg::ST_IDLE;
					cmd_done <= 1'b1;
					if (!seg_final) begin
						expect_ofs <= seg_stop;
					end else begin
						expect_ofs <= 16'h0000;
						if (sub == `SUB_OFS_DEFER) begin
							if (verify_ok) begin
								pending <= 1'b1;
							end else begin
								err_reg[`ERR_ABORT_BIT] <= 1'b1;
								status_err              <= 1'b1;
							end
						end else if (verify_ok & ~rfail) begin
							pending     <= 1'b0;
							fw_activate <= 1'b1;
							spin_down   <= nospin;
						end else begin
							err_reg[`ERR_UNC_BIT] <= 1'b1;
							status_err            <= 1'b1;
						end
					end
				end
				default: begin
					state <= mcode_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence s_abort_out;
		cmd_done & err_reg[`ERR_ABORT_BIT] & status_err;
	endsequence

	sequence s_quiet_done;
		cmd_done & (err_reg == 8'h00) & (state == mcode_pkg::ST_IDLE);
	endsequence

	opcode_check_a: assert property (
		go & (go_opc != `OPC_DOWNLOAD) |=> s_abort_out)
		else $error("foreign opcode not aborted");

	bad_sub_a: assert property (
		go & ~sub_ok |=> s_abort_out ##0 ~fw_activate)
		else $error("undefined subcommand not aborted");

	lock_abort_a: assert property (
		go & locked |=> s_abort_out ##1 (state == mcode_pkg::ST_IDLE))
		else $error("locked device accepted command");

	zero_count_a: assert property (
		go & ~bad_cmd & ~ofs_bad & ~sub_0f & (blocks == 16'h0000) |=> s_quiet_done)
		else $error("zero count did not finish at once");

	data_start_a: assert property (
		go & ~bad_cmd & ~act_bad & ~ofs_bad & ~sub_0f & (blocks != 16'h0000) |=>
		(state == mcode_pkg::ST_XFER))
		else $error("counted command did not start data");

	ofs_discard_a: assert property (
		go & ~bad_cmd & ofs_bad |=> s_abort_out ##0 (expect_ofs == 16'h0000))
		else $error("offset gap not aborted");

	defer_store_a: assert property (
		fin_defer & verify_ok |=> pending & ~fw_activate & cmd_done)
		else $error("deferred image not held pending");

	immediate_a: assert property (
		fin_now & ~fin_defer & verify_ok & ~rfail |=> fw_activate & ~pending)
		else $error("immediate image not activated");

	activate_a: assert property (
		$rose(fw_activate) |-> $past(fin_imm) | ($past(act_req) & $past(pending)))
		else $error("activation without cause");

	unc_cause_a: assert property (
		$rose(err_reg[`ERR_UNC_BIT]) |-> $past(fin_now) | $past(act_req))
		else $error("uncorrectable without reload");

	spin_down_a: assert property (
		spin_down |-> fw_activate & $past(nospin))
		else $error("spin down without reload");

	err_status_a: assert property (
		cmd_done & (err_reg[`ERR_ABORT_BIT] | err_reg[`ERR_UNC_BIT]) |-> status_err)
		else $error("error bit missing from status");

endmodule

`default_nettype wire

/* File: rtl/mcode_map.svh */
// register offsets, command codes, field positions and counts
// assumes a 32-bit register bus with one word per register
`ifndef MCODE_MAP_SVH
`define MCODE_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CMD         8'h00
`define OFS_COUNT       8'h04
`define OFS_LBA         8'h08
`define OFS_DATA        8'h0c
`define OFS_CTRL        8'h10
`define OFS_STAT        8'h14

// ----------------------------------------------------------------
// command and subcommand codes
// ----------------------------------------------------------------
`define OPC_DOWNLOAD    8'h92
`define SUB_OFS_SAVE    8'h03
`define SUB_SAVE        8'h07
`define SUB_OFS_DEFER   8'h0e
`define SUB_ACTIVATE    8'h0f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LBA_OFS_MSB     23
`define LBA_OFS_LSB     8
`define LBA_CNTHI_MSB   7
`define ERR_ABORT_BIT   2
`define ERR_UNC_BIT     6
`define STS_ERR_BIT     0
`define STS_DRQ_BIT     3
`define STS_BSY_BIT     7
`define STAT_PEND_BIT   16
`define CTRL_LOCK_BIT   0
`define CTRL_NOSPIN_BIT 1
`define CTRL_RFAIL_BIT  2
`define CTRL_SIZE_MSB   31
`define CTRL_SIZE_LSB   16

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CTRL_RESET      32'h0000_0000
`define BLK_LAST_WORD   7'h7f
`define HSIZE_WORD      3'h2

`endif

/* File: rtl/mcode_pkg.sv */
// types used by the download handler for its command sequencer
// assumes nothing of its surroundings
`default_nettype none

package mcode_pkg;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_XFER   = 3'b010,
		ST_FINISH = 3'b100
	} cmd_state_e;

endpackage

`default_nettype wire

/* File: rtl/img_if.sv */
// carrier between the command handler and the image checker
// assumes both ends share one clock
`timescale 1ns/1ns
`default_nettype none

interface img_if;
	logic        clear;
	logic        restart;
	logic        word_valid;
	logic [31:0] word;
	logic [31:0] sum;
	logic        block_done;

	modport mgr (output clear, output restart, output word_valid, output word,
		input sum, input block_done);
	modport chk (input clear, input restart, input word_valid, input word,
		output sum, output block_done);
endinterface

`default_nettype wire

/* File: rtl/img_checker.sv */
// image checker: word-in-block count and running image checksum
// assumes words arrive one per cycle at most, from the handler
`timescale 1ns/1ns
`default_nettype none
`include "mcode_map.svh"

module img_checker (
	input wire logic clk,
	input wire logic rstn,
	img_if.chk       img
);
	logic [6:0] word_idx;

	// ----------------------------------------------------------------
	// position inside the current 512-byte block
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			word_idx <= 7'h00;
		end else if (img.restart) begin
			word_idx <= 7'h00;
		end else if (img.word_valid) begin
			word_idx <= word_idx + 7'h01;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			img.block_done <= 1'b0;
		end else begin
			img.block_done <= img.word_valid & ~img.restart &
				(word_idx == `BLK_LAST_WORD);
		end
	end

	// ----------------------------------------------------------------
	// checksum over the whole image, kept across segments
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			img.sum <= 32'h0000_0000;
		end else if (img.clear) begin
			img.sum <= 32'h0000_0000;
		end else if (img.word_valid) begin
			img.sum <= img.sum + img.word;
		end
	end
endmodule

`default_nettype wire

/* File: dv/host_model.sv */
// host-side bus master: register accesses, commands and image data
// assumes the handler is the only slave, its hreadyout fed back as hready
`timescale 1ns/1ns
`default_nettype none
`include "mcode_map.svh"

module host_model (
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	logic [31:0] sum;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = `HSIZE_WORD;
		hwdata = 32'h0;
		sum = 32'h0;
	end

	// ----------------------------------------------------------------
	// one single word transfer; call just after a rising edge
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, {24'h0, a}, d, q);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, {24'h0, a}, 32'h0, q);
	endtask

	// ----------------------------------------------------------------
	// command block, then the opcode write that starts it
	// ----------------------------------------------------------------
	task automatic issue(input logic [7:0] op, input logic [7:0] sub,
		input logic [15:0] ofs, input logic [15:0] cnt);
		wr(`OFS_COUNT, {24'h0, cnt[7:0]});
		wr(`OFS_LBA, {8'h0, ofs, cnt[15:8]});
		wr(`OFS_CMD, {16'h0, sub, op});
	endtask

	// ----------------------------------------------------------------
	// whole blocks of image words; last word zeroes the image sum
	// ----------------------------------------------------------------
	task automatic send(input int nblk, input logic first, input logic last);
		logic [31:0] w;
		if (first) begin
			sum = 32'h0;
		end
		for (int i = 0; i < nblk * 128; i++) begin
			w = 32'h0000_1000 + 32'(i);
			if (last && i == nblk * 128 - 1) begin
				w = 32'h0 - sum;
			end
			sum = sum + w;
			wr(`OFS_DATA, w);
		end
	endtask
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the firmware-download command handler
// assumes the host model is the only bus master
`timescale 1ns/1ns
`default_nettype none
`include "mcode_map.svh"

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tb_top;
	logic        clk;
	logic        rstn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        fw_activate;
	logic        spin_down;
	logic        cmd_done;
	int          errors;
	int          checks;
	int          cycles;
	int          dones;
	int          acts;
	int          spins;
	int          d0;
	int          a0;
	int          s0;

	mcode_handler i_mcode_handler (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.fw_activate(fw_activate), .spin_down(spin_down), .cmd_done(cmd_done));

	host_model i_host_model (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	initial begin
		clk = 1'b0;
	end

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// pulse counters and hang limit
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		dones += int'(cmd_done === 1'b1);
		acts += int'(fw_activate === 1'b1);
		spins += int'(spin_down === 1'b1);
		if (cycles == 12000) begin
			$display("Error at %0t: timeout", $time);
			errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	// pulses since last call, then pending, uncorrectable, abort, error
	task automatic outcome(input int nd, input int na, input int ns, input logic [3:0] st);
		logic [31:0] q;
		repeat (8) @(posedge clk);
		`CHK(dones - d0, nd)
		`CHK(acts - a0, na)
		`CHK(spins - s0, ns)
		i_host_model.rd(`OFS_STAT, q);
		`CHK({q[`STAT_PEND_BIT], q[14], q[10], q[`STS_ERR_BIT]}, st)
		d0 = dones;
		a0 = acts;
		s0 = spins;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs();
		logic [31:0] q;
		i_host_model.rd(`OFS_CTRL, q);
		`CHK(q, `CTRL_RESET)
		i_host_model.wr(8'h20, 32'hffff_ffff);
		i_host_model.rd(8'h20, q);
		`CHK(q, 32'h0)
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
		outcome(0, 0, 0, 4'b0000);
		$display("test regs done");
	endtask

	task automatic t_abort();
		logic [23:0] bad [6];
		bad = '{24'h91_07_00, 24'h92_00_00, 24'h92_05_00, 24'h92_ff_00, 24'h92_07_01,
			24'h92_0f_00};
		for (int k = 0; k < 6; k++) begin
			i_host_model.wr(`OFS_CTRL, {24'h0, bad[k][7:0]});
			i_host_model.issue(bad[k][23:16], bad[k][15:8], 16'h0, 16'h0001);
			outcome(1, 0, 0, 4'b0011);
		end
		i_host_model.wr(`OFS_CTRL, 32'h0001_0002);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_SAVE, 16'h0, 16'h0000);
		outcome(1, 0, 0, 4'b0000);
		$display("test abort done");
	endtask

	task automatic t_save();
		logic [31:0] q;
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_SAVE, 16'h0005, 16'h0001);
		i_host_model.rd(`OFS_STAT, q);
		`CHK(q[`STS_DRQ_BIT], 1'b1)
		i_host_model.send(1, 1'b1, 1'b1);
		outcome(1, 1, 1, 4'b0000);
		$display("test save done");
	endtask

	task automatic t_defer();
		i_host_model.wr(`OFS_CTRL, 32'h0003_0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_DEFER, 16'h0000, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b0);
		outcome(1, 0, 0, 4'b0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_DEFER, 16'h0001, 16'h0002);
		i_host_model.send(2, 1'b0, 1'b1);
		outcome(1, 0, 0, 4'b1000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_ACTIVATE, 16'h0, 16'h0);
		outcome(1, 1, 0, 4'b0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_ACTIVATE, 16'h0, 16'h0);
		outcome(1, 0, 0, 4'b0011);
		$display("test defer done");
	endtask

	task automatic t_order();
		logic [31:0] q;
		i_host_model.wr(`OFS_CTRL, 32'h0004_0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0000, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b0);
		outcome(1, 0, 0, 4'b0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0002, 16'h0001);
		outcome(1, 0, 0, 4'b0011);
		i_host_model.rd(`OFS_CMD, q);
		`CHK(q, {16'h0000, `SUB_OFS_SAVE, `OPC_DOWNLOAD})
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0001, 16'h0001);
		outcome(1, 0, 0, 4'b0011);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0000, 16'h0004);
		i_host_model.send(4, 1'b1, 1'b1);
		outcome(1, 1, 0, 4'b0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0000, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b0);
		outcome(1, 0, 0, 4'b0000);
		do_reset();
		i_host_model.wr(`OFS_CTRL, 32'h0004_0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_SAVE, 16'h0001, 16'h0001);
		outcome(1, 0, 0, 4'b0011);
		$display("test order done");
	endtask

	task automatic t_unc();
		i_host_model.wr(`OFS_CTRL, 32'h0001_0006);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_SAVE, 16'h0, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b1);
		outcome(1, 0, 0, 4'b0101);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_DEFER, 16'h0, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b1);
		outcome(1, 0, 0, 4'b1000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_ACTIVATE, 16'h0, 16'h0);
		outcome(1, 0, 0, 4'b0101);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_OFS_DEFER, 16'h0, 16'h0001);
		i_host_model.send(1, 1'b1, 1'b1);
		outcome(1, 0, 0, 4'b1000);
		do_reset();
		outcome(0, 0, 0, 4'b0000);
		i_host_model.issue(`OPC_DOWNLOAD, `SUB_ACTIVATE, 16'h0, 16'h0);
		outcome(1, 0, 0, 4'b0011);
		$display("test unc done");
	endtask

	initial begin
		rstn = 1'b0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		t_regs();
		t_abort();
		t_save();
		t_defer();
		t_order();
		t_unc();
		final_report();
	end
endmodule

`default_nettype wire
